// >>> src/ccrg_clock_gen.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The codec clock follows the integer divider path or the loop divided path as selected.
// - The divider input mux picks master clock, pin two or bit clock, master clock after reset.
// - The integer divider divides its input by Q, any whole value from 2 through 17.
// - With the loop bypassed the divider output is itself the reference sample rate.
// - The loop input mux picks among the same three clocks independently of the divider mux.
// - The loop output rates follow from P, K and R applied to the selected loop input.
// - ADC and DAC rates each come from the reference rate through their own divisor.
// - Each converter path has its own dual-rate option that doubles its derived rate when its divisor is above one.
module ccrg_clock_gen (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic master_clock_pin,
   input wire logic multipurpose_pin_two,
   input wire logic bit_clock_pin,
   input wire logic cfg_wr,
   input wire ccrg_pkg::ccrg_cfg_s cfg_in,
   output ccrg_pkg::ccrg_cfg_s cfg_active,
   output ccrg_pkg::ccrg_ticks_s ticks
);

   // ************************************************************
   // Configuration holding register.
   // ************************************************************
   ccrg_pkg::ccrg_cfg_s cfg;
   ccrg_pkg::ccrg_cfg_s next_cfg;

   // Settings move only on a write, so a half-updated ratio is never seen.
   always_comb begin
      next_cfg = cfg;
      if (cfg_wr) begin
         next_cfg = cfg_in;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg <= ccrg_pkg::CFG_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end

   assign cfg_active = cfg;

   // ************************************************************
   // Pin synchronisers and edge detection.
   // ************************************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   logic [2:0] pin_edge;

   // Bit 0 master clock, bit 1 pin two, bit 2 bit clock; sync_a feeds only sync_b.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         sync_c <= 3'h0;
      end else begin
         sync_a <= {bit_clock_pin, multipurpose_pin_two, master_clock_pin};
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   assign pin_edge = sync_b & ~sync_c;

   // Both muxes pick rising edges; unused code 3 falls back to the master clock.
   function automatic logic pick_edge(input logic [1:0] sel, input logic [2:0] edges);
      logic result;
      result = edges[0];
      case (sel)
         ccrg_pkg::SRC_MULTIPURPOSE_PIN_TWO: result = edges[1];
         ccrg_pkg::SRC_BIT_CLOCK: result = edges[2];
         default: result = edges[0];
      endcase
      return result;
   endfunction

   logic div_edge;
   logic loop_edge;

   assign div_edge = pick_edge(cfg.divider_src, pin_edge);
   // The loop only earns credit while it feeds the codec clock, so a bypassed loop stays idle.
   assign loop_edge = pick_edge(cfg.loop_src, pin_edge)
      & (cfg.codec_src == ccrg_pkg::CODEC_FROM_LOOP);

   // ************************************************************
   // Integer divider.
   // ************************************************************
   logic [4:0] q_ratio;
   logic [4:0] div_cnt;
   logic [4:0] next_div_cnt;
   logic next_div_out;
   logic div_out;

   assign q_ratio = {1'b0, cfg.q_code} + ccrg_pkg::Q_OFFSET;

   // A count left above a freshly shortened Q wraps on the next input edge, so no long stall follows.
   always_comb begin
      next_div_cnt = div_cnt;
      next_div_out = 1'b0;
      if (div_edge) begin
         if (div_cnt >= q_ratio - 5'h01) begin
            next_div_cnt = 5'h00;
            next_div_out = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= 5'h00;
         div_out <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         div_out <= next_div_out;
      end
   end

   // ************************************************************
   // Loop path: credit accumulator standing in for the analog loop.
   // ************************************************************
   logic [3:0] p_ratio;
   logic [5:0] k_eff;
   logic [4:0] r_ratio;
   logic [10:0] kr_gain;
   logic [11:0] credit;
   logic [11:0] next_credit;
   logic [12:0] credit_sum;
   logic next_loop_out;
   logic loop_out;
   logic [1:0] post_cnt;
   logic [1:0] next_post_cnt;
   logic next_loop_div;
   logic loop_div;

   assign p_ratio = {1'b0, cfg.p_code} + ccrg_pkg::P_OFFSET;
   assign k_eff = (cfg.k_value == 6'h00) ? ccrg_pkg::K_MIN : cfg.k_value;
   assign r_ratio = {1'b0, cfg.r_code} + ccrg_pkg::R_OFFSET;
   assign kr_gain = 11'(k_eff * r_ratio);

   // Each input edge earns K times R credits and each output pulse spends P. One pulse per
   // cycle at most, so a ratio above the cycle rate saturates instead of overflowing.
   always_comb begin
      credit_sum = {1'b0, credit};
      if (loop_edge) begin
         credit_sum = credit_sum + {2'b00, kr_gain};
      end
      next_loop_out = 1'b0;
      if (credit_sum >= {9'h000, p_ratio}) begin
         next_loop_out = 1'b1;
         credit_sum = credit_sum - {9'h000, p_ratio};
      end
      if (credit_sum > {1'b0, ccrg_pkg::CREDIT_MAX}) begin
         next_credit = ccrg_pkg::CREDIT_MAX;
      end else begin
         next_credit = credit_sum[11:0];
      end
      next_post_cnt = post_cnt;
      next_loop_div = 1'b0;
      if (loop_out) begin
         next_post_cnt = post_cnt + 2'h1;
         next_loop_div = (post_cnt == ccrg_pkg::LOOP_POST_DIV_LAST);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         credit <= 12'h000;
         loop_out <= 1'b0;
         post_cnt <= 2'h0;
         loop_div <= 1'b0;
      end else begin
         credit <= next_credit;
         loop_out <= next_loop_out;
         post_cnt <= next_post_cnt;
         loop_div <= next_loop_div;
      end
   end

   // ************************************************************
   // Codec clock mux and converter rate dividers.
   // ************************************************************
   logic next_fs_ref;
   logic fs_ref;
   logic [3:0] adc_n;
   logic [3:0] dac_n;
   logic [3:0] adc_step;
   logic [3:0] dac_step;
   logic [3:0] adc_acc;
   logic [3:0] dac_acc;
   logic [3:0] next_adc_acc;
   logic [3:0] next_dac_acc;
   logic next_adc_tick;
   logic next_dac_tick;
   logic adc_tick;
   logic dac_tick;

   assign adc_n = {1'b0, cfg.adc_rate_divisor} + ccrg_pkg::N_OFFSET;
   assign dac_n = {1'b0, cfg.dac_rate_divisor} + ccrg_pkg::N_OFFSET;
   // Dual rate with a divisor of one cannot exceed one tick per reference tick.
   assign adc_step = cfg.adc_dual_rate && adc_n > 4'h1 ? ccrg_pkg::STEP_DUAL : ccrg_pkg::STEP_SINGLE;
   assign dac_step = cfg.dac_dual_rate && dac_n > 4'h1 ? ccrg_pkg::STEP_DUAL : ccrg_pkg::STEP_SINGLE;

   // The reference tick comes from whichever path the codec mux selects.
   always_comb begin
      next_fs_ref = (cfg.codec_src == ccrg_pkg::CODEC_FROM_LOOP) ? loop_div : div_out;
      next_adc_acc = adc_acc;
      next_dac_acc = dac_acc;
      next_adc_tick = 1'b0;
      next_dac_tick = 1'b0;
      if (fs_ref) begin
         next_adc_acc = adc_acc + adc_step;
         next_dac_acc = dac_acc + dac_step;
         if (next_adc_acc >= adc_n) begin
            next_adc_acc = next_adc_acc - adc_n;
            next_adc_tick = 1'b1;
         end
         if (next_dac_acc >= dac_n) begin
            next_dac_acc = next_dac_acc - dac_n;
            next_dac_tick = 1'b1;
         end
      end
      // A divisor lowered below the residue clears it to keep the count in range.
      if (next_adc_acc >= adc_n) begin
         next_adc_acc = 4'h0;
      end
      if (next_dac_acc >= dac_n) begin
         next_dac_acc = 4'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fs_ref <= 1'b0;
         adc_acc <= 4'h0;
         dac_acc <= 4'h0;
         adc_tick <= 1'b0;
         dac_tick <= 1'b0;
      end else begin
         fs_ref <= next_fs_ref;
         adc_acc <= next_adc_acc;
         dac_acc <= next_dac_acc;
         adc_tick <= next_adc_tick;
         dac_tick <= next_dac_tick;
      end
   end

   assign ticks = '{
      integer_divider_output: div_out,
      loop_output: loop_out,
      loop_divided_output: loop_div,
      fs_ref_tick: fs_ref,
      adc_rate_tick: adc_tick,
      dac_rate_tick: dac_tick
   };

   // ************************************************************
   // Assertions and covers.
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   codec_loop_path_a: assert property (cfg.codec_src && loop_div |=> fs_ref)
      else $error("loop divided tick did not reach the reference tick");
   fs_ref_source_a: assert property (fs_ref |-> $past(cfg.codec_src ? loop_div : div_out))
      else $error("reference tick without a tick on the selected path");
   reset_default_a: assert property (!$past(rstn) |-> cfg == ccrg_pkg::CFG_RESET)
      else $error("configuration not at its reset value after reset");
   div_wrap_a: assert property (div_edge && div_cnt == q_ratio - 5'h01 |=> div_out)
      else $error("divider did not pulse on the Q-th edge");
   div_bound_a: assert property (div_out |-> div_cnt == 5'h00 ##1 div_cnt < q_ratio)
      else $error("divider count out of range");
   bypass_ref_a: assert property (!cfg.codec_src && div_out && !cfg_wr |=> fs_ref)
      else $error("bypass divider tick did not become the reference tick");
   loop_src_sel_a: assert property (cfg.loop_src == ccrg_pkg::SRC_BIT_CLOCK && loop_edge
      |-> pin_edge[2])
      else $error("loop mux did not follow the bit clock");
   loop_spend_a: assert property (loop_out |-> $past(credit) + ($past(loop_edge) ?
      13'($past(kr_gain)) : 13'h0000) >= 13'($past(p_ratio)))
      else $error("loop pulse without enough credit");
   adc_from_ref_a: assert property (adc_tick |-> $past(fs_ref))
      else $error("ADC tick without a reference tick");
   adc_unity_a: assert property (adc_n == 4'h1 && fs_ref && !cfg_wr |=> adc_tick)
      else $error("ADC divisor of one missed a reference tick");
   cfg_hold_a: assert property (!$past(cfg_wr) |-> $stable(cfg))
      else $error("configuration changed without a write");
   cfg_load_a: assert property (cfg_wr |=> cfg == $past(cfg_in))
      else $error("configuration write not taken");

   loop_path_c: cover property (cfg.codec_src && fs_ref);
   bypass_path_c: cover property (!cfg.codec_src && fs_ref ##[1:40] fs_ref);
   adc_dual_c: cover property (cfg.adc_dual_rate && adc_n > 4'h2 && adc_tick);
   cfg_change_c: cover property (cfg_wr ##1 $changed(cfg));

endmodule

// >>> src/ccrg_pkg.sv
package ccrg_pkg;

   // ************************************************************
   // Clock source selection codes shared by both input muxes.
   // ************************************************************
   localparam logic [1:0] SRC_MASTER_CLOCK = 2'h0;
   localparam logic [1:0] SRC_MULTIPURPOSE_PIN_TWO = 2'h1;
   localparam logic [1:0] SRC_BIT_CLOCK = 2'h2;

   // Codec clock mux codes.
   localparam logic CODEC_FROM_DIVIDER = 1'b0;
   localparam logic CODEC_FROM_LOOP = 1'b1;

   // ************************************************************
   // Field offsets that turn stored codes into working ratios.
   // ************************************************************
   localparam logic [4:0] Q_OFFSET = 5'h02;
   localparam logic [3:0] P_OFFSET = 4'h1;
   localparam logic [4:0] R_OFFSET = 5'h01;
   localparam logic [3:0] N_OFFSET = 4'h1;
   localparam logic [5:0] K_MIN = 6'h01;

   // Fixed post divider between the loop output and its divided output.
   localparam logic [1:0] LOOP_POST_DIV_LAST = 2'h3;

   // Saturation limit of the loop credit accumulator.
   localparam logic [11:0] CREDIT_MAX = 12'hfff;

   // Converter rate steps per reference tick, single and dual rate.
   localparam logic [3:0] STEP_SINGLE = 4'h1;
   localparam logic [3:0] STEP_DUAL = 4'h2;

   // ************************************************************
   // Configuration word written by the host.
   // ************************************************************
   typedef struct packed {
      logic codec_src;
      logic [1:0] divider_src;
      logic [1:0] loop_src;
      logic [3:0] q_code;
      logic [2:0] p_code;
      logic [5:0] k_value;
      logic [3:0] r_code;
      logic [2:0] adc_rate_divisor;
      logic [2:0] dac_rate_divisor;
      logic adc_dual_rate;
      logic dac_dual_rate;
   } ccrg_cfg_s;

   localparam ccrg_cfg_s CFG_RESET = '{
      codec_src: CODEC_FROM_DIVIDER,
      divider_src: SRC_MASTER_CLOCK,
      loop_src: SRC_MASTER_CLOCK,
      q_code: 4'h0,
      p_code: 3'h0,
      k_value: 6'h01,
      r_code: 4'h0,
      adc_rate_divisor: 3'h0,
      dac_rate_divisor: 3'h0,
      adc_dual_rate: 1'b0,
      dac_dual_rate: 1'b0
   };

   // Output ticks of the block, each a one-cycle pulse except loop_output, which can stay high on consecutive cycles.
   typedef struct packed {
      logic integer_divider_output;
      logic loop_output;
      logic loop_divided_output;
      logic fs_ref_tick;
      logic adc_rate_tick;
      logic dac_rate_tick;
   } ccrg_ticks_s;

endpackage

// >>> testbench/ccrg_clock_source.sv
`timescale 1ns/1ps
// ************************************************************
// Model of one external clock source driving a codec clock pin.
// ************************************************************
module ccrg_clock_source #(
   parameter int HALF_NS = 100
) (
   input wire logic go,
   input wire logic [7:0] edges,
   output logic pin,
   output logic done
);
   // The clock stands still low between bursts, so every tick counted comes from a burst.
   initial begin
      pin = 1'b0;
      done = 1'b1;
      forever begin
         @(posedge go);
         done = 1'b0;
         repeat (edges) begin
            #(HALF_NS) pin = 1'b1;
            #(HALF_NS) pin = 1'b0;
         end
         done = 1'b1;
      end
   end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk;
   logic rstn;
   logic cfg_wr;
   ccrg_pkg::ccrg_cfg_s cfg_in;
   ccrg_pkg::ccrg_cfg_s cfg_active;
   ccrg_pkg::ccrg_ticks_s ticks;
   logic [2:0] pin;
   logic [2:0] done;
   logic go;
   logic clr;
   logic [7:0] e[3];
   int n[6];
   int fails;
   int checked;
   int cycles;

   // ************************************************************
   // Design, three source models and tick counters.
   // ************************************************************
   ccrg_clock_gen ccrg_clock_gen_inst (.ref_clk(ref_clk), .rstn(rstn),
      .master_clock_pin(pin[0]), .multipurpose_pin_two(pin[1]), .bit_clock_pin(pin[2]),
      .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_active(cfg_active), .ticks(ticks));
   // Unequal half periods give the pins different rates, each period a whole multiple of the reference period.
   // The rates are scaled far down from audio rates, so only the ratios are checked here.
   ccrg_clock_source #(.HALF_NS(100)) src0_inst (.go(go), .edges(e[0]), .pin(pin[0]),
      .done(done[0]));
   ccrg_clock_source #(.HALF_NS(140)) src1_inst (.go(go), .edges(e[1]), .pin(pin[1]),
      .done(done[1]));
   ccrg_clock_source #(.HALF_NS(180)) src2_inst (.go(go), .edges(e[2]), .pin(pin[2]),
      .done(done[2]));

   // Index 5 counts divider ticks down to index 0 for the DAC rate ticks.
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 6; i++) begin
         n[i] <= clr ? 0 : n[i] + int'(ticks[i]);
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // A hang ends the run as a failure instead of running on.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails = fails + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(string what, int exp, int got);
      checked = checked + 1;
      if (exp != got) begin
         fails = fails + 1;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic do_reset(int len);
      @(posedge ref_clk) #2 rstn = 1'b0;
      repeat (len) @(posedge ref_clk);
      #2 rstn = 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask

   // The host loads the word; nothing computed outside reaches the clocks.
   task automatic write(ccrg_pkg::ccrg_cfg_s c);
      @(posedge ref_clk) #2 cfg_wr = 1'b1;
      cfg_in = c;
      @(posedge ref_clk) #2 cfg_wr = 1'b0;
   endtask

   // Counters clear, the sources run their bursts, then the tick pipeline drains.
   task automatic burst(int a, int b, int c);
      @(posedge ref_clk) #2 e[0] = 8'(a);
      e[1] = 8'(b);
      e[2] = 8'(c);
      go = 1'b1;
      clr = 1'b1;
      @(posedge ref_clk) #2 go = 1'b0;
      clr = 1'b0;
      for (int i = 0; i < 2000 && done !== 3'b111; i++) @(posedge ref_clk);
      repeat (60) @(posedge ref_clk);
   endtask

   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_reset();
      if (cfg_active !== ccrg_pkg::CFG_RESET) begin
         fails = fails + 1;
         $display("mismatch cfg_active expected %h seen %h", ccrg_pkg::CFG_RESET, cfg_active);
      end
      checked = checked + 1;
      burst(4, 9, 9);
      check("div_default", 2, n[5]);
      check("fs_default", 2, n[2]);
   endtask

   task automatic t_sources();
      ccrg_pkg::ccrg_cfg_s c;
      int exp[4] = '{3, 6, 9, 3};
      for (int s = 0; s < 4; s++) begin
         do_reset(2);
         c = ccrg_pkg::CFG_RESET;
         c.divider_src = 2'(s);
         write(c);
         burst(6, 12, 18);
         check("div_src", exp[s], n[5]);
      end
   endtask

   task automatic t_ratio();
      ccrg_pkg::ccrg_cfg_s c;
      int q[3] = '{2, 5, 17};
      for (int i = 0; i < 3; i++) begin
         do_reset(2);
         c = ccrg_pkg::CFG_RESET;
         c.q_code = 4'(q[i] - 2);
         write(c);
         burst(34, 0, 0);
         check("div_q", 34 / q[i], n[5]);
         check("fs_q", 34 / q[i], n[2]);
         check("loop_unused", 0, n[3]);
      end
   endtask

   // Loop path from the bit clock while the divider watches pin two. P=3, K=2, R=3.
   task automatic t_loop();
      ccrg_pkg::ccrg_cfg_s c;
      do_reset(2);
      c = ccrg_pkg::CFG_RESET;
      c.codec_src = ccrg_pkg::CODEC_FROM_LOOP;
      c.divider_src = ccrg_pkg::SRC_MULTIPURPOSE_PIN_TWO;
      c.loop_src = ccrg_pkg::SRC_BIT_CLOCK;
      c.p_code = 3'h2;
      c.k_value = 6'h02;
      c.r_code = 4'h2;
      write(c);
      burst(10, 10, 24);
      check("div_indep", 5, n[5]);
      check("loop_out", 48, n[4]);
      check("loop_div", 12, n[3]);
      check("fs_loop", 12, n[2]);
   endtask

   task automatic t_rates();
      ccrg_pkg::ccrg_cfg_s c;
      int ac[3] = '{3, 2, 0};
      int ad[3] = '{1, 0, 1};
      int dc[3] = '{2, 3, 1};
      int dd[3] = '{0, 1, 0};
      for (int i = 0; i < 3; i++) begin
         do_reset(2);
         c = ccrg_pkg::CFG_RESET;
         c.adc_rate_divisor = 3'(ac[i]);
         c.adc_dual_rate = 1'(ad[i]);
         c.dac_rate_divisor = 3'(dc[i]);
         c.dac_dual_rate = 1'(dd[i]);
         write(c);
         burst(24, 0, 0);
         check("adc_rate", 12 * ((ad[i] == 1 && ac[i] > 0) ? 2 : 1) / (ac[i] + 1), n[1]);
         check("dac_rate", 12 * ((dd[i] == 1 && dc[i] > 0) ? 2 : 1) / (dc[i] + 1), n[0]);
      end
   endtask

   // A changed word without a write strobe must not reach the clocks.
   task automatic t_hold();
      ccrg_pkg::ccrg_cfg_s c;
      do_reset(2);
      c = ccrg_pkg::CFG_RESET;
      c.q_code = 4'h1;
      write(c);
      cfg_in.q_code = 4'hf;
      cfg_in.codec_src = ccrg_pkg::CODEC_FROM_LOOP;
      repeat (5) @(posedge ref_clk);
      checked = checked + 1;
      if (cfg_active !== c) begin
         fails = fails + 1;
         $display("mismatch cfg_hold expected %h seen %h", c, cfg_active);
      end
      burst(9, 0, 0);
      check("div_hold", 3, n[5]);
   endtask

   initial begin
      rstn = 1'b0;
      cfg_wr = 1'b0;
      cfg_in = ccrg_pkg::CFG_RESET;
      go = 1'b0;
      clr = 1'b1;
      e = '{8'h00, 8'h00, 8'h00};
      fails = 0;
      checked = 0;
      cycles = 0;
      do_reset(8);
      t_reset();
      t_sources();
      t_ratio();
      t_loop();
      t_rates();
      t_hold();
      conclude();
   end
endmodule
